// file: hdl/tle_core.sv
// Overview of operation
// - Commit exposes all region accesses at once
// - Region stores stay buffered until commit
// - Abort drops buffer, restores state, runs plainly
// - Track read and write sets per line
// - Remote read of write line conflicts; writes too
// - A data conflict aborts the region
// - Tracking capacity exhaustion aborts the region
// - System events inside a region abort it
// - Hinted acquire: no write, read-set, enter region
// - Elided lock keeps its external value
// - Own lock read returns the acquired value
// - Restoring hinted release: suppress write, no write-set
// - Elided release attempts the commit
// - Failed hinted region reruns with real lock
// - Without elision, hints are ignored repeat prefixes
// - Begin opens and end closes explicit regions
// - Query reports whether region is active
// - Abort instruction forces a region abort
// - Explicit abort restarts at fallback with status
// - In explicit regions, abort immediate lands in accumulator register
// - Hints count nesting; region starts leaving zero
`timescale 1ns/100ps
`default_nettype none
`include "tle_defs.svh"

module tle_core (
  // Clock, reset and enable
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  // Configuration
  input  wire logic                   legacy_hint_elision,
  // Operation from the pipeline
  input  wire logic                   op_valid,
  input  wire tle_pkg::tle_op_type    op_kind,
  input  wire logic                   elide_acquire_hint,
  input  wire logic                   elide_release_hint,
  input  wire logic [`TLE_ADDR_W-1:0] op_pc,
  input  wire logic [`TLE_ADDR_W-1:0] op_addr,
  input  wire logic [`TLE_DATA_W-1:0] op_data,
  input  wire logic [`TLE_DATA_W-1:0] op_old_data,
  input  wire logic [`TLE_IMM_W-1:0]  op_imm,
  input  wire logic [`TLE_ADDR_W-1:0] op_fallback,
  output logic                        op_ready_q,
  // Abort-causing system event
  input  wire logic                   sys_event,
  // Coherence requests from other processors
  input  wire logic                   snp_valid,
  input  wire logic                   snp_write,
  input  wire logic [`TLE_ADDR_W-1:0] snp_addr,
  output logic                        coh_hold_q,
  // Memory write port
  output logic                        mem_wr_valid_q,
  output logic [`TLE_ADDR_W-1:0]      mem_wr_addr_q,
  output logic [`TLE_DATA_W-1:0]      mem_wr_data_q,
  // Load forwarding
  output logic                        ld_fwd_valid_q,
  output logic [`TLE_DATA_W-1:0]      ld_fwd_data_q,
  // Query
  output logic                        query_valid_q,
  output logic                        query_txn_q,
  // Region status and recovery
  output logic                        txn_active_q,
  output logic                        explicit_transaction_mode_q,
  output logic                        commit_q,
  output logic                        abort_q,
  output logic                        rollback_q,
  output logic                        restart_valid_q,
  output logic [`TLE_ADDR_W-1:0]      restart_addr_q,
  output logic                        acc_wr_valid_q,
  output logic [`TLE_DATA_W-1:0]      accumulator_register_q,
  output logic                        no_elide_q
);

  tle_pkg::tle_state_type state_q;
  tle_pkg::tle_state_type state_d;

  logic [`TLE_NEST_W-1:0]   nest_q;
  logic                     lock_valid_q;
  logic [`TLE_ADDR_W-1:0]   lock_addr_q;
  logic [`TLE_DATA_W-1:0]   lock_old_q;
  logic [`TLE_DATA_W-1:0]   lock_new_q;
  logic [`TLE_ADDR_W-1:0]   fallback_q;
  logic [`TLE_ADDR_W-1:0]   entry_pc_q;
  logic [`TLE_ADDR_W-1:0]   wb_addr_q [`TLE_WB_DEPTH];
  logic [`TLE_DATA_W-1:0]   wb_data_q [`TLE_WB_DEPTH];
  logic [`TLE_WB_IDX_W:0]   wb_cnt_q;
  logic [`TLE_WB_IDX_W:0]   drain_q;

  logic                     in_txn;
  logic                     op_go;
  logic                     elide_on;
  logic                     acq_hint;
  logic                     rel_hint;
  logic                     lock_acq;
  logic                     rel_ok;
  logic                     rel_bad;
  logic                     begin_op;
  logic                     end_op;
  logic                     txn_abort_op;
  logic                     nest_up;
  logic                     nest_dn;
  logic                     nest_over;
  logic                     txn_store;
  logic                     plain_store;
  logic                     txn_load;
  logic                     wb_full;
  logic                     set_conflict;
  logic                     set_overflow;
  logic                     capacity;
  logic                     abort_now;
  logic                     commit_now;
  logic                     enter;
  logic                     drain_last;
  logic [`TLE_DATA_W-1:0]   abort_status;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  assign in_txn   = (state_q == tle_pkg::ST_TXN);
  assign op_go    = ce && op_valid && op_ready_q;
  // Hints only act when elision is on and not in a fallback rerun
  assign elide_on = legacy_hint_elision && !no_elide_q;
  assign acq_hint = op_go && op_kind == tle_pkg::OP_LOCKED && elide_acquire_hint && elide_on;
  assign rel_hint = op_go && op_kind == tle_pkg::OP_LOCKED && elide_release_hint && elide_on &&
                    in_txn;
  assign lock_acq = acq_hint && !lock_valid_q;
  assign rel_ok   = rel_hint && lock_valid_q && op_addr == lock_addr_q &&
                    op_data == lock_old_q;
  assign rel_bad  = rel_hint && lock_valid_q && op_addr == lock_addr_q && op_data != lock_old_q;
  assign begin_op = op_go && op_kind == tle_pkg::OP_BEGIN;
  assign end_op   = op_go && op_kind == tle_pkg::OP_END && in_txn;
  assign txn_abort_op   = op_go && op_kind == tle_pkg::OP_ABORT && in_txn;
  assign nest_up  = acq_hint || begin_op;
  assign nest_dn  = rel_hint || end_op;
  assign nest_over = in_txn && nest_up && nest_q == `TLE_NEST_MAX;
  assign txn_store = in_txn && op_go && (op_kind == tle_pkg::OP_STORE ||
                     (op_kind == tle_pkg::OP_LOCKED && !lock_acq && !rel_ok));
  assign plain_store = !in_txn && op_go && (op_kind == tle_pkg::OP_STORE ||
                       (op_kind == tle_pkg::OP_LOCKED && !lock_acq));
  assign txn_load  = in_txn && op_go && op_kind == tle_pkg::OP_LOAD;
  assign wb_full   = txn_store && wb_cnt_q == (`TLE_WB_IDX_W+1)'(`TLE_WB_DEPTH);
  assign capacity  = set_overflow || wb_full;
  assign abort_now = in_txn && (set_conflict || capacity || sys_event || txn_abort_op ||
                     nest_over || rel_bad);
  assign commit_now = in_txn && !abort_now && nest_dn && nest_q == `TLE_NEST_ONE;
  assign enter      = state_q == tle_pkg::ST_IDLE && (lock_acq || begin_op);
  assign drain_last = (drain_q + (`TLE_WB_IDX_W+1)'(1)) == wb_cnt_q;

  tle_line_sets u_sets (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .ce        (ce),
    .clear     (abort_now || commit_now),
    .add_valid (txn_load || lock_acq || txn_store),
    .add_write (txn_store),
    .add_line  (op_addr[`TLE_ADDR_W-1:`TLE_LINE_LSB]),
    .snp_valid (snp_valid && in_txn),
    .snp_write (snp_write),
    .snp_line  (snp_addr[`TLE_ADDR_W-1:`TLE_LINE_LSB]),
    .conflict  (set_conflict),
    .overflow  (set_overflow)
  );

  always_comb begin
    abort_status = '0;
    abort_status[`TLE_ABT_EXPLICIT] = txn_abort_op;
    abort_status[`TLE_ABT_CONFLICT] = set_conflict;
    abort_status[`TLE_ABT_CAPACITY] = capacity;
    abort_status[`TLE_ABT_NESTED]   = nest_over;
    if (txn_abort_op) begin
      abort_status[`TLE_ABT_IMM_MSB:`TLE_ABT_IMM_LSB] = op_imm;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      tle_pkg::ST_IDLE: begin
        if (enter) begin
          state_d = tle_pkg::ST_TXN;
        end
      end
      tle_pkg::ST_TXN: begin
        if (abort_now) begin
          state_d = tle_pkg::ST_IDLE;
        end else if (commit_now) begin
          // A store taken in the commit cycle still has to drain
          state_d = (wb_cnt_q == '0 && !txn_store) ? tle_pkg::ST_IDLE : tle_pkg::ST_DRAIN;
        end
      end
      tle_pkg::ST_DRAIN: begin
        if (drain_last) begin
          state_d = tle_pkg::ST_IDLE;
        end
      end
      default: state_d = tle_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Region state and nesting
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q      <= tle_pkg::ST_IDLE;
      op_ready_q   <= 1'h0;
      txn_active_q <= 1'h0;
    end else if (ce) begin
      state_q      <= state_d;
      op_ready_q   <= (state_d != tle_pkg::ST_DRAIN);
      txn_active_q <= (state_d == tle_pkg::ST_TXN);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      nest_q <= '0;
    end else if (ce) begin
      if (abort_now || commit_now) begin
        nest_q <= '0;
      end else if (nest_up && (enter || in_txn)) begin
        nest_q <= nest_q + `TLE_NEST_ONE;
      end else if (nest_dn) begin
        nest_q <= nest_q - `TLE_NEST_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      explicit_transaction_mode_q <= 1'h0;
      fallback_q                  <= '0;
      entry_pc_q                  <= '0;
    end else if (ce && enter) begin
      explicit_transaction_mode_q <= begin_op;
      fallback_q                  <= op_fallback;
      entry_pc_q                  <= op_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Elided lock tracking
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lock_valid_q <= 1'h0;
      lock_addr_q  <= '0;
      lock_old_q   <= '0;
      lock_new_q   <= '0;
    end else if (ce) begin
      if (abort_now || commit_now || rel_ok) begin
        lock_valid_q <= 1'h0;
      end else if (lock_acq) begin
        lock_valid_q <= 1'h1;
        lock_addr_q  <= op_addr;
        lock_old_q   <= op_old_data;
        lock_new_q   <= op_data;
      end
    end
  end

  // A failed hinted region reruns with the lock really taken
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      no_elide_q <= 1'h0;
    end else if (ce) begin
      if (abort_now && !explicit_transaction_mode_q) begin
        no_elide_q <= 1'h1;
      end else if (op_go && !in_txn && op_kind == tle_pkg::OP_LOCKED && elide_release_hint) begin
        no_elide_q <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Store buffer
  always_ff @(posedge sys_clk) begin
    if (ce && txn_store && !wb_full) begin
      wb_addr_q[wb_cnt_q[`TLE_WB_IDX_W-1:0]] <= op_addr;
      wb_data_q[wb_cnt_q[`TLE_WB_IDX_W-1:0]] <= op_data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_cnt_q <= '0;
      drain_q  <= '0;
    end else if (ce) begin
      if (abort_now || (state_q == tle_pkg::ST_DRAIN && drain_last)) begin
        wb_cnt_q <= '0;
        drain_q  <= '0;
      end else if (state_q == tle_pkg::ST_DRAIN) begin
        drain_q <= drain_q + (`TLE_WB_IDX_W+1)'(1);
      end else if (txn_store && !wb_full) begin
        wb_cnt_q <= wb_cnt_q + (`TLE_WB_IDX_W+1)'(1);
      end
    end
  end

  // Remote requests are held off while buffered stores drain
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mem_wr_valid_q <= 1'h0;
      mem_wr_addr_q  <= '0;
      mem_wr_data_q  <= '0;
      coh_hold_q     <= 1'h0;
    end else if (ce) begin
      coh_hold_q     <= (state_q == tle_pkg::ST_DRAIN);
      mem_wr_valid_q <= plain_store || state_q == tle_pkg::ST_DRAIN;
      if (state_q == tle_pkg::ST_DRAIN) begin
        mem_wr_addr_q <= wb_addr_q[drain_q[`TLE_WB_IDX_W-1:0]];
        mem_wr_data_q <= wb_data_q[drain_q[`TLE_WB_IDX_W-1:0]];
      end else if (plain_store) begin
        mem_wr_addr_q <= op_addr;
        mem_wr_data_q <= op_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load forwarding and query
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ld_fwd_valid_q <= 1'h0;
      ld_fwd_data_q  <= '0;
      query_valid_q  <= 1'h0;
      query_txn_q    <= 1'h0;
    end else if (ce) begin
      ld_fwd_valid_q <= txn_load && lock_valid_q && op_addr == lock_addr_q;
      ld_fwd_data_q  <= lock_new_q;
      query_valid_q  <= op_go && op_kind == tle_pkg::OP_QUERY;
      query_txn_q    <= in_txn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit and abort reporting
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      commit_q               <= 1'h0;
      abort_q                <= 1'h0;
      rollback_q             <= 1'h0;
      restart_valid_q        <= 1'h0;
      restart_addr_q         <= '0;
      acc_wr_valid_q         <= 1'h0;
      accumulator_register_q <= '0;
    end else if (ce) begin
      commit_q        <= commit_now;
      abort_q         <= abort_now;
      rollback_q      <= abort_now;
      restart_valid_q <= abort_now;
      acc_wr_valid_q  <= abort_now && explicit_transaction_mode_q;
      if (abort_now) begin
        restart_addr_q <= explicit_transaction_mode_q ? fallback_q : entry_pc_q;
      end
      if (abort_now && explicit_transaction_mode_q) begin
        accumulator_register_q <= abort_status;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_conflict_abort: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && in_txn && set_conflict) |=> (abort_q && !txn_active_q))
    else $error("conflict did not abort the region");

  a_elided_acquire: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && lock_acq && !abort_now) |=> (!mem_wr_valid_q && txn_active_q))
    else $error("elided acquire issued a write or stayed out of region");

  a_store_withheld: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && in_txn) |=> !mem_wr_valid_q)
    else $error("store left the core during a region");

  a_drain_atomic: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && state_q == tle_pkg::ST_DRAIN) |-> !op_ready_q ##1 (coh_hold_q && mem_wr_valid_q))
    else $error("commit drain not held atomic");

  a_abort_drops: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && abort_now) |=> (wb_cnt_q == '0 && rollback_q && nest_q == '0))
    else $error("abort kept buffered state");

  a_lock_forward: assert property (@(posedge sys_clk) disable iff (!nrst)
    (txn_load && lock_valid_q && op_addr == lock_addr_q) |=>
      (ld_fwd_valid_q && ld_fwd_data_q == $past(lock_new_q)))
    else $error("own lock read did not return acquired value");

  a_release_commit: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rel_ok && nest_q == `TLE_NEST_ONE && !abort_now) |=> (commit_q && !txn_active_q))
    else $error("elided release did not commit");

  a_query_state: assert property (@(posedge sys_clk) disable iff (!nrst)
    (op_go && op_kind == tle_pkg::OP_QUERY) |=> (query_valid_q && query_txn_q == $past(in_txn)))
    else $error("query returned wrong region state");

  a_abort_imm: assert property (@(posedge sys_clk) disable iff (!nrst)
    (txn_abort_op && explicit_transaction_mode_q) |=>
      (acc_wr_valid_q && accumulator_register_q[`TLE_ABT_IMM_MSB:`TLE_ABT_IMM_LSB] ==
       $past(op_imm)))
    else $error("abort immediate not loaded");

  a_fallback_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && abort_now && explicit_transaction_mode_q) |=>
      (restart_valid_q && restart_addr_q == $past(fallback_q)))
    else $error("explicit abort did not restart at fallback");

  a_legacy_hints: assert property (@(posedge sys_clk) disable iff (!nrst)
    (op_go && !legacy_hint_elision && state_q == tle_pkg::ST_IDLE &&
     op_kind == tle_pkg::OP_LOCKED) |=> (mem_wr_valid_q && !txn_active_q))
    else $error("hint acted with elision disabled");

endmodule : tle_core
`default_nettype wire

// file: hdl/tle_defs.svh
`ifndef TLE_DEFS_SVH
`define TLE_DEFS_SVH

// Datapath widths
`define TLE_ADDR_W 32
`define TLE_DATA_W 32
`define TLE_IMM_W 8
`define TLE_LINE_LSB 6
`define TLE_LINE_W 26

// Tracking capacity
`define TLE_SET_ENTRIES 8
`define TLE_SET_IDX_W 3
`define TLE_WB_DEPTH 8
`define TLE_WB_IDX_W 3

// Nesting
`define TLE_NEST_W 3
`define TLE_NEST_MAX 3'h7
`define TLE_NEST_ONE 3'h1

// Abort status word loaded into the accumulator register
`define TLE_ABT_EXPLICIT 0
`define TLE_ABT_CONFLICT 2
`define TLE_ABT_CAPACITY 3
`define TLE_ABT_NESTED 5
`define TLE_ABT_IMM_LSB 24
`define TLE_ABT_IMM_MSB 31

`endif

// file: hdl/tle_pkg.sv
package tle_pkg;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_LOAD,
    OP_STORE,
    OP_LOCKED,
    OP_BEGIN,
    OP_END,
    OP_QUERY,
    OP_ABORT
  } tle_op_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TXN,
    ST_DRAIN
  } tle_state_type;

endpackage : tle_pkg

// file: hdl/tle_line_sets.sv
`timescale 1ns/100ps
`default_nettype none
`include "tle_defs.svh"

module tle_line_sets (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  // Region tracking
  input  wire logic                   clear,
  input  wire logic                   add_valid,
  input  wire logic                   add_write,
  input  wire logic [`TLE_LINE_W-1:0] add_line,
  // Coherence requests from other processors
  input  wire logic                   snp_valid,
  input  wire logic                   snp_write,
  input  wire logic [`TLE_LINE_W-1:0] snp_line,
  // Results
  output logic                        conflict,
  output logic                        overflow
);

  logic [`TLE_LINE_W-1:0]      tag_q   [`TLE_SET_ENTRIES];
  logic                        valid_q [`TLE_SET_ENTRIES];
  logic                        rd_q    [`TLE_SET_ENTRIES];
  logic                        wr_q    [`TLE_SET_ENTRIES];
  logic [`TLE_SET_ENTRIES-1:0] add_hit;
  logic [`TLE_SET_ENTRIES-1:0] snp_hit;
  logic [`TLE_SET_IDX_W:0]     cnt_q;
  logic                        alloc;

  assign alloc    = add_valid && !(|add_hit) && (cnt_q != (`TLE_SET_IDX_W+1)'(`TLE_SET_ENTRIES));
  assign overflow = add_valid && !(|add_hit) && (cnt_q == (`TLE_SET_IDX_W+1)'(`TLE_SET_ENTRIES));
  assign conflict = snp_valid && (|snp_hit);

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < `TLE_SET_ENTRIES; i++) begin : g_entry
    assign add_hit[i] = valid_q[i] && (tag_q[i] == add_line);
    // Remote read hits write-set, remote write hits either set
    assign snp_hit[i] = valid_q[i] && (tag_q[i] == snp_line) &&
                        (wr_q[i] || (snp_write && rd_q[i]));

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        valid_q[i] <= 1'h0;
        rd_q[i]    <= 1'h0;
        wr_q[i]    <= 1'h0;
        tag_q[i]   <= '0;
      end else if (ce) begin
        if (clear) begin
          valid_q[i] <= 1'h0;
          rd_q[i]    <= 1'h0;
          wr_q[i]    <= 1'h0;
        end else if (add_valid && (add_hit[i] ||
                     (alloc && cnt_q == (`TLE_SET_IDX_W+1)'(i)))) begin
          valid_q[i] <= 1'h1;
          tag_q[i]   <= add_line;
          if (add_write) begin
            wr_q[i] <= 1'h1;
          end else begin
            rd_q[i] <= 1'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (clear) begin
        cnt_q <= '0;
      end else if (alloc) begin
        cnt_q <= cnt_q + (`TLE_SET_IDX_W+1)'(1);
      end
    end
  end

endmodule : tle_line_sets
`default_nettype wire

// file: testbench/tle_remote_proc.sv
`timescale 1ns/100ps
`default_nettype none
`include "tle_defs.svh"

module tle_remote_proc (
  // Clock and hold-off from the core
  input  wire logic                   sys_clk,
  input  wire logic                   coh_hold_q,
  // Coherence requests to the core
  output logic                        snp_valid,
  output logic                        snp_write,
  output logic [`TLE_ADDR_W-1:0]      snp_addr
);
  initial begin
    snp_valid = 1'b0;
    snp_write = 1'b0;
    snp_addr  = 32'h0000_0000;
  end

  // One request per call; holds off while the core writes out its buffer
  task automatic access(input logic wr, input logic [`TLE_ADDR_W-1:0] a);
    @(negedge sys_clk);
    while (coh_hold_q !== 1'b0)
      @(negedge sys_clk);
    snp_valid = 1'b1;
    snp_write = wr;
    snp_addr  = a;
    @(negedge sys_clk);
    snp_valid = 1'b0;
    snp_write = ~wr;
    snp_addr  = ~a;
  endtask : access
endmodule : tle_remote_proc
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "tle_defs.svh"

module tb_top;
  localparam logic [31:0] LOCK = 32'h0000_0100;
  localparam logic [31:0] DATA = 32'h0000_0200;
  logic        sys_clk, nrst, lhe, op_valid, acq, rel, sys_event, sv, sw;
  logic        rdy, hold, wv, fv, qv, qt, act, cm, ab, rb, rv, aw, xm, ne, ce;
  tle_pkg::tle_op_type op_kind;
  logic [31:0] op_pc, op_addr, op_data, op_old, op_fb, sa, wa, wd, fd, ra, acc, last_a, last_d;
  logic [7:0]  op_imm;
  int          errors, checks_done, wr_cnt;

  tle_core dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .legacy_hint_elision(lhe),
    .op_valid(op_valid), .op_kind(op_kind), .elide_acquire_hint(acq),
    .elide_release_hint(rel), .op_pc(op_pc), .op_addr(op_addr), .op_data(op_data),
    .op_old_data(op_old), .op_imm(op_imm), .op_fallback(op_fb), .op_ready_q(rdy),
    .sys_event(sys_event), .snp_valid(sv), .snp_write(sw), .snp_addr(sa),
    .coh_hold_q(hold), .mem_wr_valid_q(wv), .mem_wr_addr_q(wa), .mem_wr_data_q(wd),
    .ld_fwd_valid_q(fv), .ld_fwd_data_q(fd), .query_valid_q(qv), .query_txn_q(qt),
    .txn_active_q(act), .explicit_transaction_mode_q(xm), .commit_q(cm), .abort_q(ab),
    .rollback_q(rb), .restart_valid_q(rv), .restart_addr_q(ra), .acc_wr_valid_q(aw),
    .accumulator_register_q(acc), .no_elide_q(ne));
  tle_remote_proc rp (.sys_clk(sys_clk), .coh_hold_q(hold), .snp_valid(sv),
    .snp_write(sw), .snp_addr(sa));

  always #4 sys_clk = ~sys_clk;
  // Counts external writes seen during each cycle
  always @(posedge sys_clk) if (wv === 1'b1) begin
    wr_cnt++;
    last_a = wa;
    last_d = wd;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic op(input tle_pkg::tle_op_type k, input logic [1:0] h, input logic [31:0] a,
                    input logic [31:0] d);
    @(negedge sys_clk);
    op_valid = 1'b1;
    op_kind = k;
    {acq, rel} = h;
    op_addr = a;
    op_data = d;
    op_pc = op_pc + 32'h4;
    // Ready only changes on the rising edge, so its level here is what that edge sees
    while (rdy !== 1'b1)
      @(negedge sys_clk);
    @(negedge sys_clk);
    op_valid = 1'b0;
  endtask : op

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic complete_run;
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_hle;
    int n;
    n = wr_cnt;
    op(tle_pkg::OP_LOCKED, 2'b10, LOCK, 32'h1);
    chk(act, 1'b1);
    rp.access(1'b0, LOCK);
    chk(ab, 1'b0);
    op(tle_pkg::OP_LOAD, 2'b00, LOCK, 32'h0);
    chk({fv, fd}, {1'b1, 32'h1});
    op(tle_pkg::OP_STORE, 2'b00, DATA, 32'h5A);
    op(tle_pkg::OP_LOCKED, 2'b01, LOCK, 32'h0);
    chk({cm, act}, 2'b10);
    chk(wr_cnt - n, 0);
    cyc(3);
    chk({last_a, last_d}, {DATA, 32'h5A});
    chk(wr_cnt - n, 1);
  endtask : t_hle

  task automatic t_rtm;
    op_fb = 32'h0000_4000;
    op_imm = 8'hA5;
    op(tle_pkg::OP_BEGIN, 2'b00, 32'h0, 32'h0);
    op(tle_pkg::OP_QUERY, 2'b00, 32'h0, 32'h0);
    chk({qv, qt}, 2'b11);
    op(tle_pkg::OP_ABORT, 2'b00, 32'h0, 32'h0);
    chk({ab, aw, xm, ra}, {3'b111, op_fb});
    chk({acc[31:24], acc[0]}, {8'hA5, 1'b1});
    op(tle_pkg::OP_QUERY, 2'b00, 32'h0, 32'h0);
    chk({qv, qt}, 2'b10);
  endtask : t_rtm

  task automatic t_conf;
    int n;
    n = wr_cnt;
    op(tle_pkg::OP_BEGIN, 2'b00, 32'h0, 32'h0);
    op(tle_pkg::OP_STORE, 2'b00, DATA, 32'h77);
    rp.access(1'b0, DATA + 32'h4);
    chk({ab, act}, 2'b10);
    cyc(3);
    chk(wr_cnt - n, 0);
    op(tle_pkg::OP_BEGIN, 2'b00, 32'h0, 32'h0);
    rp.access(1'b1, DATA);
    chk(ab, 1'b0);
    op(tle_pkg::OP_END, 2'b00, 32'h0, 32'h0);
    chk(cm, 1'b1);
    op(tle_pkg::OP_BEGIN, 2'b00, 32'h0, 32'h0);
    sys_event = 1'b1;
    cyc(1);
    sys_event = 1'b0;
    chk({ab, act}, 2'b10);
  endtask : t_conf

  task automatic t_legacy;
    int n;
    lhe = 1'b0;
    n = wr_cnt;
    op(tle_pkg::OP_LOCKED, 2'b10, LOCK, 32'h1);
    chk(act, 1'b0);
    cyc(2);
    chk({8'(wr_cnt - n), last_a}, {8'h1, LOCK});
    lhe = 1'b1;
  endtask : t_legacy

  task automatic t_retry;
    logic [31:0] pc;
    int          n;
    op(tle_pkg::OP_LOCKED, 2'b10, LOCK, 32'h1);
    pc = op_pc;
    sys_event = 1'b1;
    cyc(1);
    sys_event = 1'b0;
    chk({ab, rb, rv, aw, xm, ne, ra}, {6'b111001, pc});
    n = wr_cnt;
    op(tle_pkg::OP_LOCKED, 2'b10, LOCK, 32'h1);
    chk({act, wv, wa}, {2'b01, LOCK});
    op(tle_pkg::OP_LOCKED, 2'b01, LOCK, 32'h0);
    chk({act, ne, wv, wd}, {3'b001, 32'h0});
    cyc(1);
    chk(wr_cnt - n, 2);
    op(tle_pkg::OP_BEGIN, 2'b00, 32'h0, 32'h0);
    {ce, sys_event} = 2'b01;
    cyc(2);
    {ce, sys_event} = 2'b10;
    chk({ab, act}, 2'b01);
    op(tle_pkg::OP_END, 2'b00, 32'h0, 32'h0);
    chk(cm, 1'b1);
  endtask : t_retry

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_clk, nrst, lhe, op_valid, acq, rel, sys_event, ce} = 8'b00100001;
    op_kind = tle_pkg::OP_NONE;
    {op_pc, op_addr, op_data, op_old, op_fb, op_imm} = '0;
    {errors, checks_done, wr_cnt} = '0;
    cyc(2);
    nrst = 1'b1;
    cyc(2);
    t_hle();
    t_rtm();
    t_conf();
    t_legacy();
    t_retry();
    complete_run();
  end

  initial begin
    #20000;
    errors++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
